// [logic/rpa_pkg.sv]
// Purpose: types for the registered PROM program-access block
// Assumes: nothing beyond the constants header
// Notes: mode decode of the pin-level controls
package rpa_pkg;
	typedef enum logic [2:0] {
		RPA_READ,
		RPA_PROGRAM,
		RPA_VERIFY,
		RPA_INHIBIT
	} rpa_mode_t;
endpackage

// [logic/rpa_prom.sv]
// Purpose: registered 2K x 8 PROM with init byte and enable-mode cell
// Assumes: pins sampled on clk; register clock input is a level
// Notes: erased cells read zero; programming ORs ones into a cell
`include "rpa_regs.svh"
module rpa_prom
	import rpa_pkg::*;
#(
	parameter int ADDR_W = `RPA_ADDR_W,
	parameter int DATA_W = `RPA_DATA_W,
	parameter int WORDS = `RPA_WORDS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic addressZeroHigh,
	input wire logic register_clock_input,
	input wire logic output_enable_n,
	input wire logic initialize_n,
	input wire logic initializeHigh,
	input wire logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0] dataOut,
	output logic dataOutEn,
	output logic syncEnableMode
);
	logic [DATA_W-1:0] array [WORDS];
	logic [DATA_W-1:0] initByte;
	logic modeBit;
	logic [DATA_W-1:0] outReg;
	logic syncOff;
	logic clkPrev;
	logic pgmPrev;
	logic [WORDS-1:0] programmed;

	wire logic program_strobe_n = register_clock_input;
	wire logic verify_strobe_n = output_enable_n;
	wire logic address_line_zero = addressZeroHigh;
	wire logic address_line_three = address[3];
	wire logic clkRise = register_clock_input & ~clkPrev;
	function automatic rpa_mode_t decodeMode(input logic hv,
		input logic pgmN, input logic vfyN);
		if (!hv) begin
			return RPA_READ;
		end
		if (!pgmN && vfyN) begin
			return RPA_PROGRAM;
		end
		if (pgmN && !vfyN) begin
			return RPA_VERIFY;
		end
		return RPA_INHIBIT;
	endfunction
	wire rpa_mode_t mode = decodeMode(initializeHigh, program_strobe_n,
		verify_strobe_n);
	// extra cells by high address zero
	wire logic selInit = address_line_zero & ~address_line_three;
	wire logic selMode = address_line_zero & address_line_three;
	// Program once per strobe fall so a long pulse counts as one write
	wire logic progMode = (mode == RPA_PROGRAM);
	wire logic pgmFall = progMode & ~pgmPrev;
	// Erased words read zero without clearing the whole array at reset
	wire logic [DATA_W-1:0] arrayWord =
		programmed[address] ? array[address] : '0;
	wire logic readMode = (mode == RPA_READ);
	wire logic initAct = readMode & ~initialize_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clkPrev <= 1'b0;
			pgmPrev <= 1'b0;
		end else begin
			clkPrev <= register_clock_input;
			pgmPrev <= progMode;
		end
	end

	// mode cell set by one pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			modeBit <= 1'b0;
			initByte <= `RPA_ERASED_BYTE;
		end else if (pgmFall && selInit) begin
			initByte <= initByte | dataIn;
		end else if (pgmFall && selMode) begin
			modeBit <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (pgmFall && !address_line_zero) begin
			array[address] <= arrayWord | dataIn;
		end
	end

	// erased state of the main array
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			programmed <= '0;
		end else if (pgmFall && !address_line_zero) begin
			programmed[address] <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			outReg <= `RPA_ERASED_BYTE;
			syncOff <= 1'b1;
		end else if (initAct) begin
			outReg <= initByte;
		end else if (readMode && clkRise) begin
			outReg <= arrayWord;
			syncOff <= output_enable_n;
		end
	end

	// Verify of extra cells is not provided, so only the array is shown
	wire logic [DATA_W-1:0] next_dataOut =
		(mode == RPA_VERIFY) ? arrayWord : outReg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dataOut <= '0;
		end else begin
			dataOut <= next_dataOut;
		end
	end

	assign dataOutEn = (mode == RPA_VERIFY) ||
		(readMode && (modeBit ? !syncOff : !output_enable_n));
	assign syncEnableMode = modeBit;

	// Steps of a synchronous enable and of a held program strobe
	sequence seqSyncLoadOn;
		readMode && modeBit && clkRise && initialize_n && !output_enable_n;
	endsequence

	sequence seqProgHeld;
		progMode ##1 progMode;
	endsequence

	chk_init_load_value: assert property (@(posedge clk)
		disable iff (!nrst)
		initAct |=> outReg == $past(initByte))
		else $error("init load wrong");

	chk_clock_load_data: assert property (@(posedge clk)
		disable iff (!nrst)
		readMode && clkRise && initialize_n |=> outReg == $past(arrayWord))
		else $error("register load wrong");

	chk_sync_off_edge: assert property (@(posedge clk)
		disable iff (!nrst)
		readMode && modeBit && clkRise && initialize_n && output_enable_n
		##1 readMode |-> !dataOutEn)
		else $error("sync disable missed");

	chk_async_enable: assert property (@(posedge clk)
		disable iff (!nrst)
		readMode && !modeBit |-> dataOutEn == !output_enable_n)
		else $error("async enable wrong");

	chk_mode_program: assert property (@(posedge clk)
		disable iff (!nrst)
		pgmFall && selMode |=> modeBit)
		else $error("mode cell not set");

	chk_inhibit_hiz: assert property (@(posedge clk)
		disable iff (!nrst)
		mode == RPA_INHIBIT || mode == RPA_PROGRAM |-> !dataOutEn)
		else $error("outputs driven");

	chk_sync_on_edge: assert property (@(posedge clk)
		disable iff (!nrst)
		seqSyncLoadOn ##1 readMode |-> dataOutEn)
		else $error("sync enable missed");

	chk_sync_hold: assert property (@(posedge clk)
		disable iff (!nrst)
		!(readMode && clkRise && !initAct) |=> $stable(syncOff))
		else $error("sync state moved");

	chk_init_keeps_en: assert property (@(posedge clk)
		disable iff (!nrst)
		initAct |=> $stable(syncOff))
		else $error("init moved enable");

	chk_verify_drive: assert property (@(posedge clk)
		disable iff (!nrst)
		mode == RPA_VERIFY |-> dataOutEn)
		else $error("verify not driven");

	chk_verify_data: assert property (@(posedge clk)
		disable iff (!nrst)
		mode == RPA_VERIFY |=> dataOut == $past(arrayWord))
		else $error("verify data wrong");

	chk_blank_read: assert property (@(posedge clk)
		disable iff (!nrst)
		mode == RPA_VERIFY && !programmed[address] |=> dataOut == '0)
		else $error("erased word not zero");

	chk_init_program: assert property (@(posedge clk)
		disable iff (!nrst)
		pgmFall && selInit |=> initByte == ($past(initByte) | $past(dataIn)))
		else $error("init byte not programmed");

	chk_array_program: assert property (@(posedge clk)
		disable iff (!nrst)
		pgmFall && !address_line_zero |=> programmed[$past(address)] &&
		array[$past(address)] == ($past(arrayWord) | $past(dataIn)))
		else $error("array word not programmed");

	chk_held_once: assert property (@(posedge clk)
		disable iff (!nrst)
		seqProgHeld |=> $stable(initByte) && $stable(modeBit) &&
		$stable(programmed))
		else $error("held pulse wrote twice");

	chk_mode_sticky: assert property (@(posedge clk)
		disable iff (!nrst)
		modeBit |=> modeBit)
		else $error("mode cell reverted");

	chk_outreg_hold: assert property (@(posedge clk)
		disable iff (!nrst)
		!initAct && !(readMode && clkRise) |=> $stable(outReg))
		else $error("register changed without edge");
endmodule

// [logic/rpa_regs.svh]
// Purpose: constants for the registered PROM program-access block
// Assumes: one 50 MHz clock; pin levels decoded to logic levels outside
// Notes: high programming voltage arrives as separate qualifier inputs
// Notes on behaviour
// - Main array, init byte, enable-mode bit stored
// - Erased mode bit gives asynchronous output enable
// - Init byte erased zero, seen via initialize
// - Read loads output register on clock rise
// - Control byte 00 selects asynchronous enable; code ignores the byte, any mode-cell pulse selects synchronous
// - Control byte 01 selects synchronous enable
// - Extra cells reached by high address zero
// - Initialize low loads init byte immediately
`ifndef RPA_REGS_SVH
`define RPA_REGS_SVH
`define RPA_ADDR_W 11
`define RPA_DATA_W 8
`define RPA_WORDS 2048
`define RPA_ERASED_BYTE 8'h00
`define RPA_CTL_ASYNC 8'h00
`define RPA_CTL_SYNC 8'h01
`endif

// [verif/rpa_programmer.sv]
// Purpose: programmer model. Assumes: short pulses. Notes: drives all pins
module rpa_programmer (
	input wire logic clk,
	input wire logic [7:0] dataOut,
	output logic [10:0] address,
	output logic [4:0] ctl,
	output logic [7:0] dataIn);
	timeunit 1ns;
	timeprecision 1ns;
	initial {address, ctl, dataIn} = 24'h000300;
	task automatic pins(logic [10:0] a, logic [4:0] m, logic [7:0] d, int n);
		@(posedge clk);
		{address, ctl, dataIn} <= {a, m, d};
		repeat (n) @(posedge clk);
		#1;
	endtask
	// count initial pulses, ten at most
	task automatic progByte(logic [10:0] a, logic [7:0] d, output int x);
		x = 0;
		do begin
			x++;
			pins(a, 5'h0B, d, 2);
			pins(a, 5'h0D, 8'h00, 3);
		end while (dataOut !== d && x < 10);
		// overprogram scaled by count; zero marks failure
		if (dataOut !== d)
			x = 0;
		else
			pins(a, 5'h0B, d, 4 * x);
		pins(a, 5'h0F, 8'h00, 1);
	endtask
endmodule

// [verif/tb_rpa_prom.sv]
// Purpose: PROM bench. Assumes: model drives pins. Notes: three scenarios
module tb_rpa_prom;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, nrst = 1'b0;
	int err_total = 0, total_checks = 0;
	wire logic [10:0] address;
	wire logic [4:0] ctl;
	wire logic [7:0] dataIn, dataOut;
	wire logic dataOutEn, syncMode;
	rpa_prom rpa_prom_inst (.clk(clk), .nrst(nrst), .address(address),
		.addressZeroHigh(ctl[4]), .initializeHigh(ctl[3]), .dataIn(dataIn),
		.register_clock_input(ctl[2]), .output_enable_n(ctl[1]),
		.initialize_n(ctl[0]), .dataOut(dataOut), .dataOutEn(dataOutEn),
		.syncEnableMode(syncMode));
	rpa_programmer rpa_programmer_inst (.clk(clk), .dataOut(dataOut),
		.address(address), .ctl(ctl), .dataIn(dataIn));
	initial forever #10 clk = ~clk;
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e)
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		err_total += int'(g !== e);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		err_total++;
		conclude();
	end
	task automatic tArray();
		int n;
		rpa_programmer_inst.progByte(11'h7FF, 8'hA5, n);
		chk("pulses", 8'h01, 8'(n));
		rpa_programmer_inst.pins(11'h7FF, 5'h0D, 8'h00, 3);
		chk("verify", 8'hA5, dataOut);
		chk("verify en", 8'h01, {7'h00, dataOutEn});
		rpa_programmer_inst.pins(11'h123, 5'h0D, 8'h00, 3);
		chk("blank", 8'h00, dataOut);
		rpa_programmer_inst.pins(11'h7FF, 5'h0F, 8'h00, 1);
		chk("inhibit en", 8'h00, {7'h00, dataOutEn});
		rpa_programmer_inst.pins(11'h7FF, 5'h00, 8'h00, 3);
		chk("init", 8'h00, dataOut);
		rpa_programmer_inst.pins(11'h7FF, 5'h05, 8'h00, 3);
		chk("read", 8'hA5, dataOut);
		chk("async on", 8'h01, {7'h00, dataOutEn});
		rpa_programmer_inst.pins(11'h7FF, 5'h03, 8'h00, 1);
		chk("async off", 8'h00, {7'h00, dataOutEn});
	endtask
	task automatic tSync();
		rpa_programmer_inst.pins(11'h7FF, 5'h07, 8'h00, 1);
		chk("sync off", 8'h00, {7'h00, dataOutEn});
		rpa_programmer_inst.pins(11'h7FF, 5'h01, 8'h00, 1);
		chk("sync wait", 8'h00, {7'h00, dataOutEn});
		rpa_programmer_inst.pins(11'h7FF, 5'h05, 8'h00, 3);
		chk("sync on", 8'h01, {7'h00, dataOutEn});
		chk("sync data", 8'hA5, dataOut);
		rpa_programmer_inst.pins(11'h7FF, 5'h03, 8'h00, 1);
		chk("sync keep", 8'h01, {7'h00, dataOutEn});
	endtask
	task automatic tExtra();
		chk("erased mode", 8'h00, {7'h00, syncMode});
		rpa_programmer_inst.pins(11'h000, 5'h1B, 8'h3C, 1);
		rpa_programmer_inst.pins(11'h000, 5'h1F, 8'h00, 1);
		rpa_programmer_inst.pins(11'h008, 5'h1B, 8'h00, 1);
		rpa_programmer_inst.pins(11'h000, 5'h00, 8'h00, 3);
		chk("mode", 8'h01, {7'h00, syncMode});
		chk("init byte", 8'h3C, dataOut);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		tArray();
		tExtra();
		tSync();
		conclude();
	end
endmodule
